// ---- core/lsc_pkg.sv ----
package lsc_pkg;
  // Byte addresses of the two documented words
  localparam logic [7:0] LSC_OFF_STATUS = 8'h04;
  localparam logic [7:0] LSC_OFF_CONFIG = 8'h08;
  // Interrupt block words
  localparam logic [7:0] LSC_OFF_IRQ_STAT = 8'h90;
  localparam logic [7:0] LSC_OFF_IRQ_EN   = 8'h94;
  localparam logic [7:0] LSC_OFF_IRQ_CLR  = 8'h98;
  // Status field positions
  localparam int LSC_ST_RFP   = 12;
  localparam int LSC_ST_FREQ  = 11;
  localparam int LSC_ST_LOSH  = 10;
  localparam int LSC_ST_ERRH  = 9;
  localparam int LSC_ST_SYNCH = 8;
  localparam int LSC_ST_LOS   = 2;
  localparam int LSC_ST_ERR   = 1;
  localparam int LSC_ST_SYNC  = 0;
  // Config field positions
  localparam int LSC_CF_INS   = 3;
  localparam int LSC_CF_FORCE = 2;
  localparam int LSC_CF_ROLE  = 1;
  localparam int LSC_CF_TXEN  = 0;
  // Interrupt event positions
  localparam int LSC_IRQ_N    = 5;
  localparam int LSC_EV_RFP   = 0;
  localparam int LSC_EV_FREQ  = 1;
  localparam int LSC_EV_LOS   = 2;
  localparam int LSC_EV_ERR   = 3;
  localparam int LSC_EV_SYNC  = 4;
  // Reset values
  localparam logic [31:0] LSC_RST_WORD = 32'h0000_0000;
  localparam logic        LSC_RST_BIT  = 1'b0;
  // Frame pulse period in ms
  localparam int LSC_RFP_MS = 10;
  // Pin synchroniser depth
  localparam int LSC_SYNC_FF = 3;
endpackage

// ---- core/lsc_pin_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; change taken when stages two and three agree
module lsc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;   // Metastable stage, read only by s2
  logic [W-1:0] s2_q;   // Second stage
  logic [W-1:0] s3_q;   // Third stage

  // Refuse a width the chain cannot build
  if (W < 1) begin : g_bad_w
    $error("lsc_pin_sync width must be positive");
  end

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit agreement filter holds the old value while stages differ
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dout[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

// ---- core/lsc_regs.sv ----
`timescale 1ns/1ps
// Layer 1 status and configuration registers behind APB
module lsc_regs #(
  parameter bit SYNC_MODE_SLAVE = 1'b0,  // Reset value of the role bit
  parameter bit DEBUG_EN        = 1'b1,  // Debug mismatch output driven; tied low when 0
  parameter int CTRL_ENTRIES    = 256    // Control word table entries
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_rfp,              // Frame pulse, async
  input  wire logic        rx_freq_mismatch,    // Mismatch pulse, async
  input  wire logic        rx_los,              // Loss of signal level
  input  wire logic        line_code_violation, // 8b10b violation
  input  wire logic        sync_hdr_violation,  // 64b66b violation
  input  wire logic        mode_64b66b,         // Line coding select
  input  wire logic        rx_hfnsync,          // Hyperframe sync level
  input  wire logic        ctrl_entry_valid,    // Control slot reached
  input  wire logic        ctrl_entry_flag,     // Entry insert flag
  output logic             ctrl_insert,         // Write control byte
  output logic             tx_enable,           // Transmit gate
  output logic             self_sync_test,      // Slave self sync
  output logic             slave_role,          // 1 is slave
  output logic             dbg_freq_alarm,      // Raw mismatch debug
  output logic             irq
);
  localparam int NIN = 6;
  localparam int NEV = lsc_pkg::LSC_IRQ_N;  // Interrupt event count

  logic [NIN-1:0] pin_s;          // Synchronised pin inputs
  logic           rfp_d1_q;       // Previous frame pulse level
  logic           frq_d1_q;       // Previous mismatch level
  logic           rfp_ev;         // Frame pulse rising edge
  logic           frq_ev;         // Mismatch rising edge
  logic           los_s;          // Synced loss of signal
  logic           err_s;          // Synced line error per mode
  logic           sync_s;         // Synced hyperframe sync
  logic [12:0]    status_q;       // Live status fields
  logic [3:0]     config_q;       // Config fields
  logic [NEV-1:0] ist_q;          // Sticky interrupt status
  logic [NEV-1:0] ien_q;          // Interrupt enables
  logic [NEV-1:0] iev;            // Interrupt events
  logic           acc;            // Access phase strobe
  logic           wr;             // Write strobe
  logic           rd_status;      // Read of status word
  logic [31:0]    rd_mux;         // Read data select
  logic           hit;            // Mapped address

  // Refuse a table size the insertion path cannot serve
  if (CTRL_ENTRIES < 1) begin : g_bad_entries
    $error("lsc_regs needs control entries");
  end

  // All link side inputs are foreign to pclk
  lsc_pin_sync #(.W(NIN)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({rx_rfp, rx_freq_mismatch, rx_los, line_code_violation,
               sync_hdr_violation, rx_hfnsync}),
    .dout    (pin_s)
  );

  // Edge history for pulse style inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfp_d1_q <= 1'b0;
      frq_d1_q <= 1'b0;
    end else begin
      rfp_d1_q <= pin_s[5];
      frq_d1_q <= pin_s[4];
    end
  end

  assign rfp_ev = pin_s[5] & ~rfp_d1_q;
  assign frq_ev = pin_s[4] & ~frq_d1_q;
  assign los_s  = pin_s[3];
  // Error source follows the line coding in use
  assign err_s  = mode_64b66b ? pin_s[1] : pin_s[2];
  assign sync_s = pin_s[0];

  // Zero wait APB: answer in the access cycle
  assign acc       = psel & penable;
  assign wr        = acc & pwrite;
  assign rd_status = acc & ~pwrite & (paddr == lsc_pkg::LSC_OFF_STATUS);

  // Address decode for reads
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == lsc_pkg::LSC_OFF_STATUS) begin
      // Word as it stands after this edge, so a set here is not lost
      rd_mux[12:0] = {status_q[12:8] |
                      {rfp_ev, frq_ev, los_s, err_s, sync_s},
                      5'h00, los_s, err_s, sync_s};
    end else if (paddr == lsc_pkg::LSC_OFF_CONFIG) begin
      rd_mux[3:0] = config_q;
    end else if (paddr == lsc_pkg::LSC_OFF_IRQ_STAT) begin
      rd_mux[NEV-1:0] = ist_q;
    end else if (paddr == lsc_pkg::LSC_OFF_IRQ_EN) begin
      rd_mux[NEV-1:0] = ien_q;
    end else if (paddr == lsc_pkg::LSC_OFF_IRQ_CLR) begin
      rd_mux = 32'h0000_0000;  // Write only, reads zero
    end else begin
      hit = 1'b0;
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Status fields; new events win over the read clear
  // Cleared at the access edge; the returned word was built at the setup
  // edge with that edge's events in it, so nothing slips between the two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 13'h0000;
    end else begin
      status_q[lsc_pkg::LSC_ST_RFP] <= rfp_ev |
        (status_q[lsc_pkg::LSC_ST_RFP] & ~rd_status);
      status_q[lsc_pkg::LSC_ST_FREQ] <= frq_ev |
        (status_q[lsc_pkg::LSC_ST_FREQ] & ~rd_status);
      status_q[lsc_pkg::LSC_ST_LOSH] <= los_s |
        (status_q[lsc_pkg::LSC_ST_LOSH] & ~rd_status);
      status_q[lsc_pkg::LSC_ST_ERRH] <= err_s |
        (status_q[lsc_pkg::LSC_ST_ERRH] & ~rd_status);
      status_q[lsc_pkg::LSC_ST_SYNCH] <= sync_s |
        (status_q[lsc_pkg::LSC_ST_SYNCH] & ~rd_status);
      status_q[7:3] <= 5'h00;
      // Live levels track their inputs; a read cannot hold them low
      status_q[lsc_pkg::LSC_ST_LOS]  <= los_s;
      status_q[lsc_pkg::LSC_ST_ERR]  <= err_s;
      status_q[lsc_pkg::LSC_ST_SYNC] <= sync_s;
    end
  end

  // Config register with byte lane zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= {1'b0, 1'b0, SYNC_MODE_SLAVE, lsc_pkg::LSC_RST_BIT};
    end else if (wr && paddr == lsc_pkg::LSC_OFF_CONFIG && pstrb[0]) begin
      config_q <= pwdata[3:0];
    end
  end

  // Interrupt events mirror the sticky status sources
  assign iev[lsc_pkg::LSC_EV_RFP]  = rfp_ev;
  assign iev[lsc_pkg::LSC_EV_FREQ] = frq_ev;
  assign iev[lsc_pkg::LSC_EV_LOS]  = los_s;
  assign iev[lsc_pkg::LSC_EV_ERR]  = err_s;
  assign iev[lsc_pkg::LSC_EV_SYNC] = sync_s;

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (wr && paddr == lsc_pkg::LSC_OFF_IRQ_EN && pstrb[0]) begin
      ien_q <= pwdata[NEV-1:0];
    end
  end

  // Sticky interrupt status; set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else if (wr && paddr == lsc_pkg::LSC_OFF_IRQ_CLR && pstrb[0]) begin
      ist_q <= iev | (ist_q & ~pwdata[NEV-1:0]);
    end else begin
      ist_q <= iev | ist_q;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq            <= 1'b0;
      ctrl_insert    <= 1'b0;
      tx_enable      <= 1'b0;
      self_sync_test <= 1'b0;
      slave_role     <= 1'b0;
      dbg_freq_alarm <= 1'b0;
    end else begin
      irq <= |(ist_q & ien_q);
      // Insertion needs master enable and the entry's own flag
      ctrl_insert <= config_q[lsc_pkg::LSC_CF_INS] & ctrl_entry_valid &
                     ctrl_entry_flag;
      tx_enable   <= config_q[lsc_pkg::LSC_CF_TXEN];
      // Self test only meaningful in slave role; master ignores it
      self_sync_test <= config_q[lsc_pkg::LSC_CF_FORCE] &
                        config_q[lsc_pkg::LSC_CF_ROLE];
      slave_role  <= config_q[lsc_pkg::LSC_CF_ROLE];
      // Raw pulse copy; tied low when the option is off
      dbg_freq_alarm <= DEBUG_EN ? pin_s[4] : 1'b0;
    end
  end

  // Assertions
  property p_rfp_sticky;
    @(posedge pclk) disable iff (!presetn)
      rfp_ev |=> status_q[lsc_pkg::LSC_ST_RFP];
  endproperty
  a_rfp_sticky: assert property (p_rfp_sticky) else $error("rfp lost");

  property p_frq_sticky;
    @(posedge pclk) disable iff (!presetn)
      frq_ev |=> status_q[lsc_pkg::LSC_ST_FREQ];
  endproperty
  a_frq_sticky: assert property (p_frq_sticky) else $error("freq lost");

  property p_dbg;
    @(posedge pclk) disable iff (!presetn)
      ##1 dbg_freq_alarm == (DEBUG_EN && $past(pin_s[4]));
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug mismatch");

  property p_rc;
    @(posedge pclk) disable iff (!presetn)
      (rd_status && !rfp_ev) |=> !status_q[lsc_pkg::LSC_ST_RFP];
  endproperty
  a_rc: assert property (p_rc) else $error("read did not clear");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (status_q[lsc_pkg::LSC_ST_LOSH] && !rd_status) |=>
        status_q[lsc_pkg::LSC_ST_LOSH];
  endproperty
  a_hold: assert property (p_hold) else $error("los hold dropped");

  property p_los;
    @(posedge pclk) disable iff (!presetn)
      ##1 status_q[lsc_pkg::LSC_ST_LOS] == $past(los_s);
  endproperty
  a_los: assert property (p_los) else $error("los level wrong");

  property p_ins;
    @(posedge pclk) disable iff (!presetn)
      !config_q[lsc_pkg::LSC_CF_INS] |=> !ctrl_insert;
  endproperty
  a_ins: assert property (p_ins) else $error("insert while off");

  property p_txen;
    @(posedge pclk) disable iff (!presetn)
      ##1 tx_enable == $past(config_q[lsc_pkg::LSC_CF_TXEN]);
  endproperty
  a_txen: assert property (p_txen) else $error("tx gate wrong");

  // Setup step of a status read
  sequence s_status_setup;
    psel && !penable && !pwrite && paddr == lsc_pkg::LSC_OFF_STATUS;
  endsequence

  // A pulse landing on the setup edge must reach the returned word
  property p_rd_rfp_kept;
    @(posedge pclk) disable iff (!presetn)
      (s_status_setup ##0 rfp_ev) |=> prdata[lsc_pkg::LSC_ST_RFP];
  endproperty
  a_rd_rfp_kept: assert property (p_rd_rfp_kept)
    else $error("rfp missed by read");

  // Setup then access with no new mismatch leaves the flag clear
  property p_rd_frq;
    @(posedge pclk) disable iff (!presetn)
      (s_status_setup ##1 (rd_status && !frq_ev)) |=>
        !status_q[lsc_pkg::LSC_ST_FREQ];
  endproperty
  a_rd_frq: assert property (p_rd_frq)
    else $error("freq not cleared by read");

  property p_err_shv;
    @(posedge pclk) disable iff (!presetn)
      (mode_64b66b && pin_s[1]) |=> status_q[lsc_pkg::LSC_ST_ERR];
  endproperty
  a_err_shv: assert property (p_err_shv)
    else $error("sync header error lost");

  property p_err_lcv;
    @(posedge pclk) disable iff (!presetn)
      (!mode_64b66b && pin_s[2]) |=> status_q[lsc_pkg::LSC_ST_ERR];
  endproperty
  a_err_lcv: assert property (p_err_lcv)
    else $error("line code error lost");

  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      ##1 status_q[lsc_pkg::LSC_ST_SYNC] == $past(sync_s);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync level wrong");

  property p_ins_flag;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_entry_flag |=> !ctrl_insert;
  endproperty
  a_ins_flag: assert property (p_ins_flag)
    else $error("insert without entry flag");

  property p_sst;
    @(posedge pclk) disable iff (!presetn)
      (config_q[lsc_pkg::LSC_CF_FORCE] && config_q[lsc_pkg::LSC_CF_ROLE])
        |=> self_sync_test;
  endproperty
  a_sst: assert property (p_sst)
    else $error("self sync test not driven");

  property p_role;
    @(posedge pclk) disable iff (!presetn)
      ##1 slave_role == $past(config_q[lsc_pkg::LSC_CF_ROLE]);
  endproperty
  a_role: assert property (p_role)
    else $error("role output wrong");
endmodule

// ---- test/lsc_regs_tb.sv ----
`timescale 1ns/1ps
// Register bench: APB calls with expected values
module lsc_regs_tb;
  // Short aliases for the register map
  localparam logic [7:0] ST = lsc_pkg::LSC_OFF_STATUS;
  localparam logic [7:0] CF = lsc_pkg::LSC_OFF_CONFIG;
  localparam logic [7:0] IS = lsc_pkg::LSC_OFF_IRQ_STAT;
  localparam logic [7:0] IE = lsc_pkg::LSC_OFF_IRQ_EN;
  localparam logic [7:0] IC = lsc_pkg::LSC_OFF_IRQ_CLR;
  logic        pclk;     // 50 MHz clock
  logic        presetn;  // Active low reset
  logic        psel;     // APB select
  logic        penable;  // APB access phase
  logic        pwrite;   // APB direction
  logic [7:0]  paddr;    // APB byte address
  logic [31:0] pwdata;   // APB write data
  logic [3:0]  strb;     // APB byte strobes
  logic [31:0] prdata;   // APB read data
  logic        pready;   // APB answer
  logic        pslverr;  // APB error
  logic [5:0]  ev;       // Line inputs: rfp,freq,los,lcv,shv,hfn
  logic        mode;     // 64b66b select
  logic        cvld;     // Control slot reached
  logic        cflg;     // Entry insert flag
  logic        cins;     // Control byte written
  logic        txen;     // Transmit gate
  logic        sst;      // Self sync test
  logic        role;     // Slave role
  logic        dbg;      // Debug mismatch
  logic        irq;      // Interrupt level
  logic        dbg_seen; // Debug pulse caught
  logic [31:0] rd;       // Last read data
  logic        er;       // Last error flag
  int          n_errors; // Mismatch count
  int          n_checks; // Compare count
  lsc_regs #(.SYNC_MODE_SLAVE(1'b0), .DEBUG_EN(1'b1),
    .CTRL_ENTRIES(256)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_rfp(ev[0]),
    .rx_freq_mismatch(ev[1]), .rx_los(ev[2]),
    .line_code_violation(ev[3]), .sync_hdr_violation(ev[4]),
    .mode_64b66b(mode), .rx_hfnsync(ev[5]),
    .ctrl_entry_valid(cvld), .ctrl_entry_flag(cflg),
    .ctrl_insert(cins), .tx_enable(txen), .self_sync_test(sst),
    .slave_role(role), .dbg_freq_alarm(dbg), .irq(irq));
  // Free running clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  // The raw pulse is short, so latch that it was seen
  always @(posedge pclk) begin
    if (!presetn) begin
      dbg_seen <= 1'b0;
    end else if (dbg === 1'b1) begin
      dbg_seen <= 1'b1;
    end
  end
  // Counted compare
  task chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One APB transfer; request held until pready seen
  task apb(input logic w, input logic [7:0] a,
           input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare one word
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, rd);
  endtask
  // Drive a line input level, then let the sync settle
  task lv(input int i, input logic v);
    @(posedge pclk);
    ev[i] <= v;
    repeat (8) @(posedge pclk);
  endtask
  // Event pulse wider than the sync depth
  task pl(input int i);
    lv(i, 1'b1);
    lv(i, 1'b0);
  endtask
  // Wait for registered outputs to follow
  task w2;
    repeat (2) @(posedge pclk);
  endtask
  // Verdict, reached by the tests or the watchdog
  task tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    strb = 4'hf;
    ev = 6'h00;
    mode = 1'b0;
    cvld = 1'b0;
    cflg = 1'b0;
    n_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    w2;
    rc(ST, 32'h0);
    rc(CF, 32'h0);
    chk("outs", 32'h0, {29'h0, sst, role, txen});
    apb(1'b1, CF, 32'h7);
    rc(CF, 32'h7);
    chk("err", 32'h0, {31'h0, er});
    w2;
    chk("outs", 32'h7, {29'h0, sst, role, txen});
    // Self test off, still slave, transmit off
    apb(1'b1, CF, 32'h2);
    w2;
    chk("outs", 32'h2, {29'h0, sst, role, txen});
    cvld <= 1'b1;
    cflg <= 1'b1;
    w2;
    chk("ins", 32'h0, {31'h0, cins});
    apb(1'b1, CF, 32'h8);
    w2;
    chk("ins", 32'h1, {31'h0, cins});
    cflg <= 1'b0;
    w2;
    chk("ins", 32'h0, {31'h0, cins});
    cvld <= 1'b0;
    // A write with lane zero off leaves the word alone
    strb <= 4'he;
    apb(1'b1, CF, 32'h0);
    strb <= 4'hf;
    rc(CF, 32'h8);
    apb(1'b1, IE, 32'h1f);
    rc(IE, 32'h1f);
    pl(0);
    chk("irq", 32'h1, {31'h0, irq});
    rc(IS, 32'h1);
    rc(ST, 32'h1000);
    rc(ST, 32'h0);
    apb(1'b1, IC, 32'h1);
    w2;
    chk("irq", 32'h0, {31'h0, irq});
    chk("dbg", 32'h0, {31'h0, dbg_seen});
    pl(1);
    chk("dbg", 32'h1, {31'h0, dbg_seen});
    rc(ST, 32'h800);
    lv(2, 1'b1);
    rc(ST, 32'h404);
    lv(2, 1'b0);
    rc(ST, 32'h400);
    rc(ST, 32'h0);
    lv(3, 1'b1);
    rc(ST, 32'h202);
    lv(3, 1'b0);
    rc(ST, 32'h200);
    // Line code error ignored in 64b66b coding
    mode <= 1'b1;
    lv(3, 1'b1);
    rc(ST, 32'h0);
    lv(4, 1'b1);
    rc(ST, 32'h202);
    lv(4, 1'b0);
    lv(3, 1'b0);
    rc(ST, 32'h200);
    lv(5, 1'b1);
    rc(ST, 32'h101);
    lv(5, 1'b0);
    rc(ST, 32'h100);
    // Masked event still sets its status bit
    apb(1'b1, IC, 32'h1f);
    apb(1'b1, IE, 32'h0);
    pl(0);
    chk("irq", 32'h0, {31'h0, irq});
    rc(IS, 32'h1);
    // Unmapped word answers with error and zero
    rc(8'h0c, 32'h0);
    chk("err", 32'h1, {31'h0, er});
    tally_and_finish;
  end
endmodule
